// *** core/npr_regs.sv ***
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
module npr_regs (
   // clock and reset
   input  wire logic                         i_core_clk,
   input  wire logic                         i_nrst,
   // axi4-lite write address
   input  wire logic                         i_awvalid,
   output logic                              o_awready,
   input  wire logic [npr_pkg::ADDR_W-1:0]   i_awaddr,
   input  wire logic [2:0]                   i_awprot,
   // axi4-lite write data
   input  wire logic                         i_wvalid,
   output logic                              o_wready,
   input  wire logic [31:0]                  i_wdata,
   input  wire logic [3:0]                   i_wstrb,
   // axi4-lite write response
   output logic                              o_bvalid,
   input  wire logic                         i_bready,
   output logic [1:0]                        o_bresp,
   // axi4-lite read address
   input  wire logic                         i_arvalid,
   output logic                              o_arready,
   input  wire logic [npr_pkg::ADDR_W-1:0]   i_araddr,
   input  wire logic [2:0]                   i_arprot,
   // axi4-lite read data
   output logic                              o_rvalid,
   input  wire logic                         i_rready,
   output logic [31:0]                       o_rdata,
   output logic [1:0]                        o_rresp,
   // negotiation side
   input  wire logic                         i_page_exchanged,
   output logic [15:0]                       o_np_code_word,
   // crossover side
   input  wire logic                         i_auto_swapped,
   output logic                              o_pair_swap_state
);

   typedef struct packed {
      logic                         aw_got;
      logic [npr_pkg::ADDR_W-1:0]   aw_addr;
      logic                         w_got;
      logic [31:0]                  w_data;
      logic [3:0]                   w_strb;
      logic                         awready;
      logic                         wready;
      logic                         bvalid;
      logic [1:0]                   bresp;
      logic                         arready;
      logic                         rvalid;
      logic [1:0]                   rresp;
      logic [31:0]                  rdata;
      logic                         more_pages;
      logic                         msg_page;
      logic                         comply_ack;
      logic                         toggle;
      logic [10:0]                  code;
      logic                         xover_auto;
      logic                         xover_force;
      logic                         pair_swap;
   } npr_state_s;

   localparam npr_state_s ST_RST = '{
      default     : '0,
      more_pages  : npr_pkg::NPT_MORE_RST,
      msg_page    : npr_pkg::NPT_MSG_RST,
      comply_ack  : npr_pkg::NPT_COMPLY_ACK_RST,
      toggle      : npr_pkg::NPT_TOG_RST,
      code        : npr_pkg::NPT_CODE_RST,
      xover_auto  : npr_pkg::PCR_AUTO_RST,
      xover_force : npr_pkg::PCR_FORCE_RST
   };

   npr_state_s   q;
   npr_state_s   d;
   logic         wr_fire;
   logic [5:0]   wr_idx;
   logic [31:0]  wr_data;
   logic [3:0]   wr_strb;
   logic [5:0]   rd_idx;

   // ack bit 14 is left 0 here; the arbitration inserts its own acknowledge
   function automatic logic [15:0] np_word(input npr_state_s s);
      logic [15:0] w;
      w = '0;
      w[npr_pkg::NPT_MORE_BIT] = s.more_pages;
      w[npr_pkg::NPT_MSG_BIT]  = s.msg_page;
      w[npr_pkg::NPT_COMPLY_ACK_BIT] = s.comply_ack;
      w[npr_pkg::NPT_TOG_BIT]  = s.toggle;
      w[npr_pkg::NPT_CODE_HI:0] = s.code;
      return w;
   endfunction : np_word

   function automatic logic is_mapped(input logic [5:0] idx);
      return idx == npr_pkg::IDX_NPT || idx == npr_pkg::IDX_STS ||
             idx == npr_pkg::IDX_ANX || idx == npr_pkg::IDX_PCR;
   endfunction : is_mapped

   function automatic logic [31:0] rd_mux(input logic [5:0] idx, input npr_state_s s);
      logic [31:0] r;
      r = '0;
      unique case (idx)
         npr_pkg::IDX_NPT: begin
            r[15:0] = np_word(s);
         end
         npr_pkg::IDX_STS: begin
            r[npr_pkg::STS_SWAP_BIT] = s.pair_swap;
         end
         npr_pkg::IDX_ANX: begin
            r[npr_pkg::ANX_NP_CAP_BIT] = npr_pkg::ANX_NP_CAP;
         end
         npr_pkg::IDX_PCR: begin
            r[npr_pkg::PCR_AUTO_BIT]  = s.xover_auto;
            r[npr_pkg::PCR_FORCE_BIT] = s.xover_force;
         end
         default: begin
            r = '0;
         end
      endcase
      return r;
   endfunction : rd_mux

   always_comb begin
      d = q;
      if (i_awvalid && q.awready) begin
         d.aw_got  = 1'b1;
         d.aw_addr = i_awaddr;
      end
      if (i_wvalid && q.wready) begin
         d.w_got  = 1'b1;
         d.w_data = i_wdata;
         d.w_strb = i_wstrb;
      end
      if (q.bvalid && i_bready) begin
         d.bvalid = 1'b0;
      end
      wr_fire = d.aw_got && d.w_got && !d.bvalid;
      wr_idx  = d.aw_addr[npr_pkg::ADDR_W-1:npr_pkg::IDX_LSB];
      wr_data = d.w_data;
      wr_strb = d.w_strb;
      // toggle first so a software write of the same word cannot mask it
      if (i_page_exchanged) begin
         d.toggle = ~q.toggle;
      end
      if (wr_fire) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = is_mapped(wr_idx) ? npr_pkg::RESP_OKAY : npr_pkg::RESP_SLVERR;
         // status and expansion accept writes silently
         if (wr_idx == npr_pkg::IDX_NPT) begin
            if (wr_strb[1]) begin
               d.more_pages = wr_data[npr_pkg::NPT_MORE_BIT];
               d.msg_page   = wr_data[npr_pkg::NPT_MSG_BIT];
               d.comply_ack = wr_data[npr_pkg::NPT_COMPLY_ACK_BIT];
               d.code[10:8] = wr_data[npr_pkg::NPT_CODE_HI:8];
            end
            if (wr_strb[0]) begin
               d.code[7:0] = wr_data[7:0];
            end
         end
         if (wr_idx == npr_pkg::IDX_PCR && wr_strb[0]) begin
            d.xover_auto  = wr_data[npr_pkg::PCR_AUTO_BIT];
            d.xover_force = wr_data[npr_pkg::PCR_FORCE_BIT];
         end
      end
      if (q.rvalid && i_rready) begin
         d.rvalid = 1'b0;
      end
      rd_idx = i_araddr[npr_pkg::ADDR_W-1:npr_pkg::IDX_LSB];
      if (i_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rdata  = rd_mux(rd_idx, q);
         d.rresp  = is_mapped(rd_idx) ? npr_pkg::RESP_OKAY : npr_pkg::RESP_SLVERR;
      end
      // force wins over the algorithm; neither set leaves pairs straight
      if (q.xover_force) begin
         d.pair_swap = 1'b1;
      end else if (q.xover_auto) begin
         d.pair_swap = i_auto_swapped;
      end else begin
         d.pair_swap = 1'b0;
      end
      d.awready = !d.aw_got && !d.bvalid;
      d.wready  = !d.w_got && !d.bvalid;
      d.arready = !d.rvalid;
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   assign o_awready         = q.awready;
   assign o_wready          = q.wready;
   assign o_bvalid          = q.bvalid;
   assign o_bresp           = q.bresp;
   assign o_arready         = q.arready;
   assign o_rvalid          = q.rvalid;
   assign o_rdata           = q.rdata;
   assign o_rresp           = q.rresp;
   assign o_np_code_word    = np_word(q);
   assign o_pair_swap_state = q.pair_swap;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_nrst);

   property p_more_pages;
      wr_fire && wr_idx == npr_pkg::IDX_NPT && wr_strb[1]
         |=> o_np_code_word[15] == $past(wr_data[15]);
   endproperty
   a_more_pages: assert property (p_more_pages) else $error("more pages not written");

   property p_np_read;
      i_arvalid && o_arready && rd_idx == npr_pkg::IDX_NPT
         |=> o_rvalid && o_rdata[14] == 1'b0 && o_rdata[15:0] == $past(o_np_code_word);
   endproperty
   a_np_read: assert property (p_np_read) else $error("next page read mismatch");

   property p_msg_page;
      wr_fire && wr_idx == npr_pkg::IDX_NPT && wr_strb[1]
         |=> o_np_code_word[13] == $past(wr_data[13]) && o_np_code_word[12] == $past(wr_data[12]);
   endproperty
   a_msg_page: assert property (p_msg_page) else $error("message or comply bit wrong");

   property p_code_low;
      wr_fire && wr_idx == npr_pkg::IDX_NPT && wr_strb[0]
         |=> o_np_code_word[7:0] == $past(wr_data[7:0]);
   endproperty
   a_code_low: assert property (p_code_low) else $error("code field not written");

   property p_toggle_flip;
      i_page_exchanged |=> o_np_code_word[11] != $past(o_np_code_word[11]);
   endproperty
   a_toggle_flip: assert property (p_toggle_flip) else $error("toggle did not invert");

   property p_toggle_hold;
      !i_page_exchanged |=> $stable(o_np_code_word[11]);
   endproperty
   a_toggle_hold: assert property (p_toggle_hold) else $error("toggle moved alone");

   property p_sts_read;
      i_arvalid && o_arready && rd_idx == npr_pkg::IDX_STS
         |=> o_rdata[15] == 1'b0 && o_rdata[14] == $past(o_pair_swap_state);
   endproperty
   a_sts_read: assert property (p_sts_read) else $error("status read mismatch");

   property p_swap_force;
      q.xover_force |=> o_pair_swap_state;
   endproperty
   a_swap_force: assert property (p_swap_force) else $error("forced swap not shown");

   property p_swap_auto;
      q.xover_auto && !q.xover_force |=> o_pair_swap_state == $past(i_auto_swapped);
   endproperty
   a_swap_auto: assert property (p_swap_auto) else $error("swap state not live");

   property p_np_capable;
      i_arvalid && o_arready && rd_idx == npr_pkg::IDX_ANX |=> o_rdata[2];
   endproperty
   a_np_capable: assert property (p_np_capable) else $error("next page capable not 1");

   property p_bresp_once;
      o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
   endproperty
   a_bresp_once: assert property (p_bresp_once) else $error("write answer dropped");

   property p_code_high;
      wr_fire && wr_idx == npr_pkg::IDX_NPT && wr_strb[1]
         |=> o_np_code_word[npr_pkg::NPT_CODE_HI:8] == $past(wr_data[npr_pkg::NPT_CODE_HI:8]);
   endproperty
   a_code_high: assert property (p_code_high) else $error("code high bits not written");

   property p_comply;
      wr_fire && wr_idx == npr_pkg::IDX_NPT && wr_strb[1]
         |=> o_np_code_word[npr_pkg::NPT_COMPLY_ACK_BIT] == $past(wr_data[npr_pkg::NPT_COMPLY_ACK_BIT]);
   endproperty
   a_comply: assert property (p_comply) else $error("comply bit not written");

   property p_msg_unfmt;
      wr_fire && wr_idx == npr_pkg::IDX_NPT && wr_strb[1] && !wr_data[npr_pkg::NPT_MSG_BIT]
         |=> !o_np_code_word[npr_pkg::NPT_MSG_BIT];
   endproperty
   a_msg_unfmt: assert property (p_msg_unfmt) else $error("unformatted page not kept");

   // only a software write may move the writable fields
   property p_word_hold;
      !(wr_fire && wr_idx == npr_pkg::IDX_NPT)
         |=> $stable(o_np_code_word[npr_pkg::NPT_MORE_BIT:npr_pkg::NPT_COMPLY_ACK_BIT]) &&
             $stable(o_np_code_word[npr_pkg::NPT_CODE_HI:0]);
   endproperty
   a_word_hold: assert property (p_word_hold) else $error("page word moved alone");

   property p_swap_off;
      !q.xover_auto && !q.xover_force |=> !o_pair_swap_state;
   endproperty
   a_swap_off: assert property (p_swap_off) else $error("swap shown with crossover off");

   property p_rdata_hold;
      o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read answer dropped");

   property p_read_unmapped;
      i_arvalid && o_arready && !is_mapped(rd_idx)
         |=> o_rresp == npr_pkg::RESP_SLVERR && o_rdata == '0;
   endproperty
   a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read answered");

   property p_write_unmapped;
      wr_fire && !is_mapped(wr_idx) |=> o_bvalid && o_bresp == npr_pkg::RESP_SLVERR;
   endproperty
   a_write_unmapped: assert property (p_write_unmapped) else $error("unmapped write answered");

   // a second write may not start before the answer of the first is taken
   property p_ready_block;
      o_bvalid |-> !o_awready && !o_wready;
   endproperty
   a_ready_block: assert property (p_ready_block) else $error("write taken during answer");

   property p_arready_block;
      o_rvalid |-> !o_arready;
   endproperty
   a_arready_block: assert property (p_arready_block) else $error("read taken during answer");

   c_write:  cover property (wr_fire && wr_idx == npr_pkg::IDX_NPT);
   c_read:   cover property (o_rvalid && i_rready);
   c_toggle: cover property (i_page_exchanged ##1 i_page_exchanged);
   c_swap:   cover property (q.xover_auto && !q.xover_force && $rose(o_pair_swap_state));
   c_bstall: cover property (o_bvalid && !i_bready);

endmodule : npr_regs

// *** core/npr_pkg.sv ***
package npr_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0]  IDX_ANX        = 6'h06;
   localparam logic [5:0]  IDX_NPT        = 6'h07;
   localparam logic [5:0]  IDX_STS        = 6'h10;
   localparam logic [5:0]  IDX_PCR        = 6'h19;
   localparam int          ADDR_W         = 8;
   localparam int          IDX_LSB        = 2;

   // next_page_transmit fields
   localparam int          NPT_MORE_BIT   = 15;
   localparam int          NPT_RSVD_BIT   = 14;
   localparam int          NPT_MSG_BIT    = 13;
   localparam int          NPT_COMPLY_ACK_BIT   = 12;
   localparam int          NPT_TOG_BIT    = 11;
   localparam int          NPT_CODE_HI    = 10;
   localparam int          NPT_CODE_W     = 11;
   localparam logic        NPT_MORE_RST   = 1'b0;
   localparam logic        NPT_MSG_RST    = 1'b1;
   localparam logic        NPT_COMPLY_ACK_RST   = 1'b0;
   localparam logic        NPT_TOG_RST    = 1'b0;
   localparam logic [10:0] NPT_CODE_RST   = 11'h001;

   // phy_status_summary and expansion fields
   localparam int          STS_RSVD_BIT   = 15;
   localparam int          STS_SWAP_BIT   = 14;
   localparam int          ANX_NP_CAP_BIT = 2;
   localparam logic        ANX_NP_CAP     = 1'b1;

   // phy_control_register fields
   localparam int          PCR_AUTO_BIT   = 1;
   localparam int          PCR_FORCE_BIT  = 0;
   localparam logic        PCR_AUTO_RST   = 1'b1;
   localparam logic        PCR_FORCE_RST  = 1'b0;

   // bus answers
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : npr_pkg

// *** testbench/npr_partner_model.sv ***
`timescale 1ns/1ns
module npr_partner_model (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_nrst,
   // bench commands
   input  wire logic i_go,
   input  wire logic i_swap,
   // device side
   output logic      o_page_exchanged,
   output logic      o_auto_swapped
);
   // one exchange per command cycle, so held commands give back-to-back pulses
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_page_exchanged <= 1'b0;
         o_auto_swapped   <= 1'b0;
      end else begin
         o_page_exchanged <= i_go;
         o_auto_swapped   <= i_swap;
      end
   end
endmodule : npr_partner_model

// *** testbench/an_next_page_tx_status_regs_tb.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; \
   if ((g) !== (e)) begin miscompares++; \
      $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module an_next_page_tx_status_regs_tb;
   logic        i_core_clk = 1'b0;
   logic        i_nrst     = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        go = 1'b0, swap = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata  = 32'h00000000;
   logic [3:0]  wstrb  = 4'h0;
   logic        awready, wready, bvalid, arready, rvalid, pg, aswp, swp_st;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, rd;
   logic [15:0] word, exp_w, d;
   logic [3:0]  s;
   int          miscompares = 0;
   int          samples_checked = 0;
   int          hold_off = 0;

   always #50 i_core_clk = ~i_core_clk;

   npr_regs dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
      .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_awprot(3'h0),
      .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
      .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
      .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .i_arprot(3'h0),
      .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
      .i_page_exchanged(pg), .o_np_code_word(word),
      .i_auto_swapped(aswp), .o_pair_swap_state(swp_st));

   npr_partner_model partner (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_go(go),
      .i_swap(swap), .o_page_exchanged(pg), .o_auto_swapped(aswp));

   task complete_run;
      $display("mismatches %0d, checks %0d", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   // each task ends one edge after its answer so no strobe is driven twice in a step
   task bus_wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] st,
               output logic [1:0] r);
      int n;
      awaddr  <= a;
      wdata   <= {16'h0000, v};
      wstrb   <= st;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= (hold_off == 0);
      for (n = 0; n < 40; n++) begin
         @(posedge i_core_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
         if (n + 1 >= hold_off) bready <= 1'b1;
      end
      if (n == 40) begin
         miscompares++;
         complete_run();
      end
      @(posedge i_core_clk);
   endtask : bus_wr

   task bus_rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] r);
      int n;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= (hold_off == 0);
      for (n = 0; n < 40; n++) begin
         @(posedge i_core_clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            dt = rdata;
            r  = rresp;
            rready <= 1'b0;
            break;
         end
         if (n + 1 >= hold_off) rready <= 1'b1;
      end
      if (n == 40) begin
         miscompares++;
         complete_run();
      end
      @(posedge i_core_clk);
   endtask : bus_rd

   // lane-masked update; reserved bit and toggle never take written data
   function automatic logic [15:0] npt_next(logic [15:0] cur, logic [15:0] v, logic [3:0] st);
      logic [15:0] m;
      m = {{8{st[1]}}, {8{st[0]}}} & 16'hB7FF;
      return (cur & ~m) | (v & m);
   endfunction : npt_next

   function automatic logic swp_exp(logic au, logic fo, logic live);
      return fo | (au & live);
   endfunction : swp_exp

   initial begin
      void'($urandom(96));
      repeat (5) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      @(posedge i_core_clk);
      exp_w = 16'h2001;
      `CHK(word, exp_w)
      `CHK(swp_st, swp_exp(1'b1, 1'b0, 1'b0))
      bus_rd(8'h1C, rd, resp);
      `CHK(rd, {16'h0000, exp_w})
      `CHK(resp, npr_pkg::RESP_OKAY)
      bus_rd(8'h18, rd, resp);
      `CHK(rd, 32'h00000004)
      for (int k = 0; k < 12; k++) begin
         d = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($urandom);
         s = (k < 2) ? 4'h3 : 4'($urandom);
         bus_wr(8'h1C, d, s, resp);
         exp_w = npt_next(exp_w, d, s);
         `CHK(resp, npr_pkg::RESP_OKAY)
         `CHK(word, exp_w)
         bus_rd(8'h1C, rd, resp);
         `CHK(rd, {16'h0000, exp_w})
         go <= 1'b1;
         repeat (k % 3 + 1) @(posedge i_core_clk);
         go <= 1'b0;
         repeat (3) @(posedge i_core_clk);
         exp_w[11] = exp_w[11] ^ ((k % 3) == 0 || (k % 3) == 2);
         `CHK(word, exp_w)
      end
      for (int k = 0; k < 8; k++) begin
         bus_wr(8'h64, {14'h0000, k[1], k[0]}, 4'h1, resp);
         swap <= k[2];
         repeat (3) @(posedge i_core_clk);
         `CHK(swp_st, swp_exp(k[1], k[0], k[2]))
         bus_rd(8'h40, rd, resp);
         `CHK(rd, {17'h00000, swp_exp(k[1], k[0], k[2]), 14'h0000})
      end
      // auto on, force off: the state must follow the algorithm without a register write
      bus_wr(8'h64, 16'h0002, 4'h1, resp);
      swap <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      `CHK(swp_st, swp_exp(1'b1, 1'b0, 1'b0))
      swap <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      `CHK(swp_st, swp_exp(1'b1, 1'b0, 1'b1))
      // stalled answers: response and read data have to stand until taken
      hold_off = 4;
      bus_wr(8'h1C, 16'h8123, 4'h3, resp);
      exp_w = npt_next(exp_w, 16'h8123, 4'h3);
      `CHK(resp, npr_pkg::RESP_OKAY)
      bus_rd(8'h1C, rd, resp);
      `CHK(rd, {16'h0000, exp_w})
      hold_off = 0;
      bus_wr(8'h40, 16'hFFFF, 4'h3, resp);
      `CHK(resp, npr_pkg::RESP_OKAY)
      bus_rd(8'h40, rd, resp);
      `CHK(rd, 32'h00004000)
      bus_wr(8'h20, 16'hFFFF, 4'h3, resp);
      `CHK(resp, npr_pkg::RESP_SLVERR)
      bus_rd(8'h20, rd, resp);
      `CHK(resp, npr_pkg::RESP_SLVERR)
      `CHK(rd, 32'h00000000)
      bus_rd(8'h1C, rd, resp);
      `CHK(rd, {16'h0000, exp_w})
      complete_run();
   end
endmodule : an_next_page_tx_status_regs_tb
